// ---- core/siap_pkg.sv ----
// constants and state type of the safety input assembly packer
package siap_pkg;

    // ------------------------------------------------------------
    // terminal counts and image sizes
    // ------------------------------------------------------------
    localparam int unsigned N_IN       = 12;
    localparam int unsigned N_TO       = 12;
    localparam int unsigned N_OUT      = 4;
    localparam int unsigned N_LAMP     = 2;
    localparam int unsigned WORD_W     = 16;
    localparam int unsigned MISC_W     = 8;
    localparam int unsigned COMB_BYTES = 3;
    localparam int unsigned VEND_BYTES = 13;
    localparam int unsigned COMB_W     = 8 * COMB_BYTES;
    localparam int unsigned VEND_W     = 8 * VEND_BYTES;
    localparam int unsigned VEND_WORDS = 7;

    // ------------------------------------------------------------
    // byte offsets inside the images, and the combined input health bit
    // ------------------------------------------------------------
    localparam int unsigned COMB_OFS_IN   = 0;
    localparam int unsigned COMB_OFS_OUTH = 2;
    localparam int unsigned COMB_CIS_BIT  = 15;
    localparam int unsigned VEND_OFS_IN   = 0;
    localparam int unsigned VEND_OFS_INH  = 2;
    localparam int unsigned VEND_OFS_TO   = 4;
    localparam int unsigned VEND_OFS_TOH  = 6;
    localparam int unsigned VEND_OFS_MON  = 8;
    localparam int unsigned VEND_OFS_OUTH = 10;
    localparam int unsigned VEND_OFS_MISC = 12;

    // ------------------------------------------------------------
    // bit positions in the miscellaneous byte
    // ------------------------------------------------------------
    localparam int unsigned MISC_OUT_SUP  = 0;
    localparam int unsigned MISC_UNIT_SUP = 1;
    localparam int unsigned MISC_COS      = 2;
    localparam int unsigned MISC_CIS      = 3;
    localparam int unsigned MISC_LAMP3    = 4;
    localparam int unsigned MISC_LAMP7    = 5;
    localparam int unsigned MISC_OUT_OC   = 6;
    localparam int unsigned MISC_UNIT_OC  = 7;

    // ------------------------------------------------------------
    // register map and event bits
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_MASK      = 8'h08;
    localparam logic [7:0] REG_COMB_LO   = 8'h10;
    localparam logic [7:0] REG_COMB_HI   = 8'h14;
    localparam logic [7:0] REG_VEND_BASE = 8'h20;
    localparam int unsigned CTRL_FREEZE  = 0;
    localparam int unsigned EV_INPUT     = 0;
    localparam int unsigned EV_OUTPUT    = 1;
    localparam int unsigned EV_TEST      = 2;
    localparam int unsigned EV_SUPPLY    = 3;
    localparam int unsigned EV_OVERCUR   = 4;
    localparam int unsigned EV_W         = 5;
    localparam logic [EV_W-1:0] MASK_RST = 5'h00;

    typedef struct packed {
        logic [COMB_W-1:0] comb;
        logic [VEND_W-1:0] vend;
        logic              freeze;
        logic [EV_W-1:0]   status;
        logic [EV_W-1:0]   mask;
        logic [31:0]       rdata;
        logic              irq;
    } siap_state_s;

endpackage

// ---- core/siap_packer.sv ----
// packer of the live terminal state into the combined and vendor input images
//
// Behaviour
// [RQ1] combined word 00: input values bits 0-11, input health bit 15
// [RQ2] combined byte 02: bits 0-3 per-output health, one means healthy
// [RQ3] vendor image: seven words at offsets 00 to 12, bits 12-15 zero
// [RQ4] each input value bit is one while its terminal is on
// [RQ5] each input health bit is zero while its terminal has an error
// [RQ6] combined input health zero if any input errs; combined bit 15, misc bit 3
// [RQ7] combined output health zero if any output errs; misc bit 2
// [RQ8] test output value word bits 0-11 show test outputs on
// [RQ9] test output health word bits 0-11 zero on test output error
// [RQ10] output monitoring word bits 0-3 show observed output state
// [RQ11] lamp flags for test outputs 3 and 7 at misc bits 4 and 5
// [RQ12] misc bit 0 zero while output supply is abnormal or off
// [RQ13] misc bit 1 zero while unit supply is abnormal or off
// [RQ14] misc bit 6 zero while output supply overcurrent is detected
// [RQ15] misc bit 7 zero while unit supply overcurrent is detected
// [RQ16] an unused input reports value zero and health one
// [RQ17] every unused image bit reads zero
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
module siap_packer (
    input  wire logic                          i_clk,
    input  wire logic                          i_reset,
    input  wire logic                          i_ce,
    input  wire logic [siap_pkg::N_IN-1:0]     i_input_on,
    input  wire logic [siap_pkg::N_IN-1:0]     i_input_err,
    input  wire logic [siap_pkg::N_IN-1:0]     i_input_used,
    input  wire logic [siap_pkg::N_TO-1:0]     i_test_output_on,
    input  wire logic [siap_pkg::N_TO-1:0]     i_test_output_err,
    input  wire logic [siap_pkg::N_OUT-1:0]    i_output_mon,
    input  wire logic [siap_pkg::N_OUT-1:0]    i_output_err,
    input  wire logic [siap_pkg::N_LAMP-1:0]   i_lamp_ok,
    input  wire logic                          i_output_supply_ok,
    input  wire logic                          i_unit_supply_ok,
    input  wire logic                          i_output_supply_oc,
    input  wire logic                          i_unit_supply_oc,
    input  wire logic [7:0]                    i_addr,
    input  wire logic [31:0]                   i_wdata,
    input  wire logic                          i_wr,
    input  wire logic                          i_rd,
    output logic      [31:0]                   o_rdata,
    output logic                               o_irq,
    output logic      [siap_pkg::COMB_W-1:0]   o_comb_image,
    output logic      [siap_pkg::VEND_W-1:0]   o_vendor_image
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    siap_pkg::siap_state_s q_ff;
    siap_pkg::siap_state_s nxt_q;

    logic [siap_pkg::N_IN-1:0]    in_val;
    logic [siap_pkg::N_IN-1:0]    in_ok;
    logic [siap_pkg::N_OUT-1:0]   out_ok;
    logic                         combined_input_health;
    logic                         combined_output_health;
    logic [siap_pkg::MISC_W-1:0]  misc;
    logic [siap_pkg::EV_W-1:0]    events;
    logic [siap_pkg::COMB_W-1:0]  comb_img;
    logic [siap_pkg::VEND_W-1:0]  vend_img;
    logic [siap_pkg::VEND_WORDS*siap_pkg::WORD_W-1:0] vend_pad;

    // ------------------------------------------------------------
    // per-terminal flags
    // ------------------------------------------------------------
    // unused inputs forced to value 0 and health 1
    assign in_val = i_input_on & i_input_used;    // RQ4 RQ16
    assign in_ok  = ~(i_input_err & i_input_used); // RQ5 RQ16
    assign out_ok = ~i_output_err;
    assign combined_input_health    = &in_ok;                        // RQ6
    assign combined_output_health    = &out_ok;                       // RQ7

    // miscellaneous diagnostic byte
    always_comb begin
        misc = '0;
        misc[siap_pkg::MISC_OUT_SUP]  = i_output_supply_ok;  // RQ12
        misc[siap_pkg::MISC_UNIT_SUP] = i_unit_supply_ok;    // RQ13
        misc[siap_pkg::MISC_COS]      = combined_output_health;                 // RQ7
        misc[siap_pkg::MISC_CIS]      = combined_input_health;                 // RQ6
        misc[siap_pkg::MISC_LAMP3]    = i_lamp_ok[0];        // RQ11
        misc[siap_pkg::MISC_LAMP7]    = i_lamp_ok[1];        // RQ11
        misc[siap_pkg::MISC_OUT_OC]   = ~i_output_supply_oc; // RQ14
        misc[siap_pkg::MISC_UNIT_OC]  = ~i_unit_supply_oc;   // RQ15
    end

    // ------------------------------------------------------------
    // image assembly
    // ------------------------------------------------------------
    // combined image, unused bits stay zero
    always_comb begin
        comb_img = '0; // RQ17
        comb_img[8*siap_pkg::COMB_OFS_IN +: siap_pkg::N_IN] = in_val; // RQ1
        comb_img[8*siap_pkg::COMB_OFS_IN + siap_pkg::COMB_CIS_BIT] = combined_input_health; // RQ1 RQ6
        comb_img[8*siap_pkg::COMB_OFS_OUTH +: siap_pkg::N_OUT] = out_ok; // RQ2
    end

    // vendor image, upper four bits of each word stay zero
    always_comb begin
        vend_img = '0; // RQ17
        vend_img[8*siap_pkg::VEND_OFS_IN +: siap_pkg::N_IN] = in_val; // RQ3
        vend_img[8*siap_pkg::VEND_OFS_INH +: siap_pkg::N_IN] = in_ok; // RQ3
        vend_img[8*siap_pkg::VEND_OFS_TO +: siap_pkg::N_TO] = i_test_output_on; // RQ8
        vend_img[8*siap_pkg::VEND_OFS_TOH +: siap_pkg::N_TO] = ~i_test_output_err; // RQ9
        vend_img[8*siap_pkg::VEND_OFS_MON +: siap_pkg::N_OUT] = i_output_mon; // RQ10
        vend_img[8*siap_pkg::VEND_OFS_OUTH +: siap_pkg::N_OUT] = out_ok; // RQ3
        vend_img[8*siap_pkg::VEND_OFS_MISC +: siap_pkg::MISC_W] = misc; // RQ3
    end

    // last word is one byte, padded for word reads
    assign vend_pad = {{(siap_pkg::VEND_WORDS*siap_pkg::WORD_W-siap_pkg::VEND_W){1'b0}}, q_ff.vend};

    // ------------------------------------------------------------
    // fault events
    // ------------------------------------------------------------
    // level events, re-set every cycle the fault stands
    always_comb begin
        events = '0;
        events[siap_pkg::EV_INPUT]   = ~combined_input_health;
        events[siap_pkg::EV_OUTPUT]  = ~combined_output_health;
        events[siap_pkg::EV_TEST]    = (|i_test_output_err) | ~(&i_lamp_ok);
        events[siap_pkg::EV_SUPPLY]  = ~i_output_supply_ok | ~i_unit_supply_ok;
        events[siap_pkg::EV_OVERCUR] = i_output_supply_oc | i_unit_supply_oc;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_q = q_ff;
        nxt_q.rdata = '0;
        // image refresh unless software froze it
        if (!q_ff.freeze) begin
            nxt_q.comb = comb_img;
            nxt_q.vend = vend_img;
        end
        // register writes
        if (i_wr) begin
            if (i_addr == siap_pkg::REG_CTRL) begin
                nxt_q.freeze = i_wdata[siap_pkg::CTRL_FREEZE];
            end else if (i_addr == siap_pkg::REG_STATUS) begin
                nxt_q.status = q_ff.status & ~i_wdata[siap_pkg::EV_W-1:0];
            end else if (i_addr == siap_pkg::REG_MASK) begin
                nxt_q.mask = i_wdata[siap_pkg::EV_W-1:0];
            end
        end
        // set wins over a write-one clear
        nxt_q.status = nxt_q.status | events;
        // register reads, data in the next cycle only
        if (i_rd) begin
            if (i_addr == siap_pkg::REG_CTRL) begin
                nxt_q.rdata = {31'h00000000, q_ff.freeze};
            end else if (i_addr == siap_pkg::REG_STATUS) begin
                nxt_q.rdata = {27'h0000000, q_ff.status};
            end else if (i_addr == siap_pkg::REG_MASK) begin
                nxt_q.rdata = {27'h0000000, q_ff.mask};
            end else if (i_addr == siap_pkg::REG_COMB_LO) begin
                nxt_q.rdata = {16'h0000, q_ff.comb[0 +: siap_pkg::WORD_W]};
            end else if (i_addr == siap_pkg::REG_COMB_HI) begin
                nxt_q.rdata = {24'h000000, q_ff.comb[siap_pkg::WORD_W +: 8]};
            end else begin
                for (int k = 0; k < siap_pkg::VEND_WORDS; k++) begin
                    if (i_addr == siap_pkg::REG_VEND_BASE + 8'(4 * k)) begin
                        nxt_q.rdata = {16'h0000, vend_pad[k*siap_pkg::WORD_W +: siap_pkg::WORD_W]};
                    end
                end
            end
        end
        // level interrupt from unmasked sticky bits
        nxt_q.irq = |(nxt_q.status & nxt_q.mask);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            q_ff.comb   <= '0;
            q_ff.vend   <= '0;
            q_ff.freeze <= 1'b0;
            q_ff.status <= '0;
            q_ff.mask   <= siap_pkg::MASK_RST;
            q_ff.rdata  <= '0;
            q_ff.irq    <= 1'b0;
        end else if (i_ce) begin
            q_ff <= nxt_q;
        end
    end

    // outputs straight from the state register
    assign o_rdata        = q_ff.rdata;
    assign o_irq          = q_ff.irq;
    assign o_comb_image   = q_ff.comb;
    assign o_vendor_image = q_ff.vend;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    logic upd;
    assign upd = i_ce && !q_ff.freeze;

    // combined value bits follow the used inputs
    chk_comb_values: assert property ( // RQ1
        upd |=> o_comb_image[siap_pkg::N_IN-1:0] == $past(i_input_on & i_input_used)
    ) else $error("combined value bits wrong");

    // combined output health byte
    chk_comb_outh: assert property ( // RQ2
        upd |=> o_comb_image[8*siap_pkg::COMB_OFS_OUTH +: siap_pkg::N_OUT] == ~$past(i_output_err)
    ) else $error("combined output health wrong");

    // spare bits of the combined image and of the vendor monitoring word read zero
    chk_unused_zero: assert property ( // RQ17
        o_comb_image[siap_pkg::COMB_CIS_BIT-1:siap_pkg::N_IN] == 3'h0
        && o_comb_image[siap_pkg::COMB_W-1:8*siap_pkg::COMB_OFS_OUTH+siap_pkg::N_OUT] == 4'h0
        && o_vendor_image[8*siap_pkg::VEND_OFS_MON+siap_pkg::WORD_W-1 -: 12] == 12'h000
    ) else $error("unused image bits not zero");

    // per-input health word
    chk_input_health: assert property ( // RQ5
        upd |=> o_vendor_image[8*siap_pkg::VEND_OFS_INH +: siap_pkg::N_IN]
                == ~$past(i_input_err & i_input_used)
    ) else $error("input health wrong");

    // all inputs unused gives value zero, health one
    chk_unused_input: assert property ( // RQ16
        upd && (i_input_used == 12'h000) |=> o_vendor_image[siap_pkg::N_IN-1:0] == 12'h000
        && o_vendor_image[8*siap_pkg::VEND_OFS_INH +: siap_pkg::N_IN] == 12'hfff
    ) else $error("unused input not reported as off and healthy");

    // combined input health in both images
    chk_global_cis: assert property ( // RQ6
        upd |=> o_comb_image[siap_pkg::COMB_CIS_BIT]
                == o_vendor_image[8*siap_pkg::VEND_OFS_MISC + siap_pkg::MISC_CIS]
        && o_comb_image[siap_pkg::COMB_CIS_BIT] == !$past(|(i_input_err & i_input_used))
    ) else $error("combined input health wrong");

    // combined output health in the misc byte
    chk_global_cos: assert property ( // RQ7
        upd |=> o_vendor_image[8*siap_pkg::VEND_OFS_MISC + siap_pkg::MISC_COS]
                == !$past(|i_output_err)
    ) else $error("combined output health wrong");

    // test output value and health words
    chk_test_words: assert property ( // RQ8 RQ9
        upd |=> o_vendor_image[8*siap_pkg::VEND_OFS_TO +: siap_pkg::N_TO] == $past(i_test_output_on)
        && o_vendor_image[8*siap_pkg::VEND_OFS_TOH +: siap_pkg::N_TO] == ~$past(i_test_output_err)
    ) else $error("test output words wrong");

    // observed safety output word
    chk_out_monitor: assert property ( // RQ10
        upd |=> o_vendor_image[8*siap_pkg::VEND_OFS_MON +: siap_pkg::N_OUT] == $past(i_output_mon)
    ) else $error("output monitoring word wrong");

    // misc byte supply, lamp and overcurrent flags, bits 2 and 3 taken from the image itself
    chk_misc_supply: assert property ( // RQ11 RQ12 RQ13 RQ14 RQ15
        upd |=> o_vendor_image[8*siap_pkg::VEND_OFS_MISC +: siap_pkg::MISC_W]
                == {!$past(i_unit_supply_oc), !$past(i_output_supply_oc), $past(i_lamp_ok),
                    o_vendor_image[8*siap_pkg::VEND_OFS_MISC + siap_pkg::MISC_CIS -: 2],
                    $past(i_unit_supply_ok), $past(i_output_supply_ok)}
    ) else $error("miscellaneous byte wrong");

    // frozen images do not move
    chk_freeze_hold: assert property ( // RQ3
        i_ce && q_ff.freeze |=> $stable(o_vendor_image) && $stable(o_comb_image)
    ) else $error("frozen image changed");

    // ------------------------------------------------------------
    // checks on vendor words, status and bus
    // ------------------------------------------------------------
    // vendor value word mirrors the used inputs that are on
    chk_vend_values: assert property ( // RQ4
        upd |=> o_vendor_image[siap_pkg::N_IN-1:0]
                == $past(i_input_on & i_input_used)
    ) else $error("vendor value word wrong");

    // vendor output health word, one means healthy
    chk_vend_outh: assert property ( // RQ3
        upd |=> o_vendor_image[8*siap_pkg::VEND_OFS_OUTH +: siap_pkg::N_OUT]
                == ~$past(i_output_err)
    ) else $error("vendor output health wrong");

    // upper nibble of the input words stays zero
    chk_vend_pad_in: assert property ( // RQ17
        o_vendor_image[8*siap_pkg::VEND_OFS_IN + siap_pkg::N_IN +: 4] == 4'h0
        && o_vendor_image[8*siap_pkg::VEND_OFS_INH + siap_pkg::N_IN +: 4] == 4'h0
    ) else $error("input word spare bits not zero");

    // upper nibble of the test output words stays zero
    chk_vend_pad_to: assert property ( // RQ17
        o_vendor_image[8*siap_pkg::VEND_OFS_TO + siap_pkg::N_TO +: 4] == 4'h0
        && o_vendor_image[8*siap_pkg::VEND_OFS_TOH + siap_pkg::N_TO +: 4] == 4'h0
    ) else $error("test word spare bits not zero");

    // output health word carries four live bits only
    chk_vend_pad_out: assert property ( // RQ17
        o_vendor_image[8*siap_pkg::VEND_OFS_OUTH + siap_pkg::N_OUT +: 12] == 12'h000
    ) else $error("output word spare bits not zero");

    // lamp flag of test output 3 sits in bit 4 of misc
    chk_lamp_flags: assert property ( // RQ11
        upd |=> o_vendor_image[8*siap_pkg::VEND_OFS_MISC + siap_pkg::MISC_LAMP3]
                == $past(i_lamp_ok[0])
    ) else $error("lamp flag wrong");

    // clock enable low holds images, bus data and interrupt
    chk_ce_hold: assert property (
        !i_ce |=> $stable(o_comb_image) && $stable(o_vendor_image)
                  && $stable(o_rdata) && $stable(o_irq)
    ) else $error("state moved with clock enable low");

    // read data stands one cycle, zero otherwise
    chk_rdata_idle: assert property (
        i_ce && !i_rd |=> o_rdata == 32'h00000000
    ) else $error("read data not zero after idle cycle");

    // interrupt level follows unmasked sticky bits
    chk_irq_level: assert property (
        o_irq == |(q_ff.status & q_ff.mask)
    ) else $error("interrupt level wrong");

    // status bits stay set unless written
    chk_status_sticky: assert property (
        i_ce && !i_wr |=> (q_ff.status & $past(q_ff.status)) == $past(q_ff.status)
    ) else $error("status bit lost");

    // output fault sets its status bit
    chk_status_out: assert property (
        i_ce && !combined_output_health |=> q_ff.status[siap_pkg::EV_OUTPUT]
    ) else $error("output fault not recorded");

    // input fault sets its status bit
    chk_status_in: assert property (
        i_ce && !combined_input_health |=> q_ff.status[siap_pkg::EV_INPUT]
    ) else $error("input fault not recorded");

    // mask write lands at the write edge
    chk_mask_write: assert property (
        i_ce && i_wr && i_addr == siap_pkg::REG_MASK
        |=> q_ff.mask == $past(i_wdata[siap_pkg::EV_W-1:0])
    ) else $error("mask write lost");

    // control write sets or clears the freeze
    chk_freeze_write: assert property (
        i_ce && i_wr && i_addr == siap_pkg::REG_CTRL
        |=> q_ff.freeze == $past(i_wdata[siap_pkg::CTRL_FREEZE])
    ) else $error("freeze write lost");

    // status read returns the registered status
    chk_status_read: assert property (
        i_ce && i_rd && i_addr == siap_pkg::REG_STATUS
        |=> o_rdata == {27'h0000000, $past(q_ff.status)}
    ) else $error("status read wrong");

    // unmapped read returns zero
    chk_unmapped_read: assert property (
        i_ce && i_rd && i_addr == 8'hfc
        |=> o_rdata == 32'h00000000
    ) else $error("unmapped read not zero");

endmodule

// ---- bench/siap_ctrl_model.sv ----
// cyclic consumer model that splits the input images into their words
module siap_ctrl_model (
    input  wire logic [siap_pkg::COMB_W-1:0] i_comb_image,
    input  wire logic [siap_pkg::VEND_W-1:0] i_vendor_image,
    output logic      [15:0]                 o_comb_word,
    output logic      [7:0]                  o_comb_byte,
    output logic      [15:0]                 o_vend_word [0:6]
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // little-endian word split at the documented byte offsets
    // ------------------------------------------------------------
    assign o_comb_word = i_comb_image[15:0];
    assign o_comb_byte = i_comb_image[23:16];
    // misc word is a single byte, upper half reads zero
    always_comb begin
        for (int w = 0; w < 6; w++) begin
            o_vend_word[w] = i_vendor_image[16*w +: 16];
        end
        o_vend_word[6] = {8'h00, i_vendor_image[103:96]};
    end
endmodule

// ---- bench/test_safety_input_assembly_packer.sv ----
// self-checking bench of the safety input assembly packer
module test_safety_input_assembly_packer;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_reset, i_ce, i_wr, i_rd, i_osup, i_usup, i_ooc, i_uoc;
    logic [11:0] i_on, i_err, i_used, i_to_on, i_to_err;
    logic [3:0]  i_mon, i_oerr;
    logic [1:0]  i_lamp;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata, d;
    logic        o_irq;
    logic [23:0] o_comb_image;
    logic [103:0] o_vendor_image, ev;
    logic [15:0] pw0;
    logic [7:0]  pb2;
    logic [15:0] pw [0:6];
    logic [11:0] pat [0:7] = '{12'h000, 12'hfff, 12'h001, 12'h800, 12'ha5a, 12'h5a5, 12'h0f0, 12'hf0f};
    int miscompares = 0, total_checks = 0, cycles = 0;

    siap_packer dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_input_on(i_on), .i_input_err(i_err),
        .i_input_used(i_used), .i_test_output_on(i_to_on), .i_test_output_err(i_to_err), .i_output_mon(i_mon),
        .i_output_err(i_oerr), .i_lamp_ok(i_lamp), .i_output_supply_ok(i_osup), .i_unit_supply_ok(i_usup),
        .i_output_supply_oc(i_ooc), .i_unit_supply_oc(i_uoc), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_comb_image(o_comb_image),
        .o_vendor_image(o_vendor_image));
    siap_ctrl_model ctrl (.i_comb_image(o_comb_image), .i_vendor_image(o_vendor_image), .o_comb_word(pw0),
        .o_comb_byte(pb2), .o_vend_word(pw));

    // ------------------------------------------------------------
    // clock, timeout and verdict
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic summarize();
        if (miscompares == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cmp_img(input logic [103:0] got, input logic [103:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ------------------------------------------------------------
    // register port cycles, read data stands one cycle only
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clk);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
        @(posedge i_clk);
        #1 cmp_reg(o_rdata, 32'h0);
    endtask
    // expected vendor image from the current terminal state
    function automatic logic [103:0] exp_vend();
        logic [11:0] vals, inh;
        logic [7:0]  misc;
        vals = i_on & i_used;
        inh  = ~(i_err & i_used);
        misc = {~i_uoc, ~i_ooc, i_lamp, &inh, ~|i_oerr, i_usup, i_osup};
        return {misc, 12'h0, ~i_oerr, 12'h0, i_mon, 4'h0, ~i_to_err, 4'h0, i_to_on, 4'h0, inh, 4'h0, vals};
    endfunction
    task automatic settle();
        repeat (2) @(posedge i_clk);
        #1 ev = exp_vend();
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {i_wr, i_rd, i_addr, i_wdata, i_ooc, i_uoc, i_lamp} = '0;
        {i_on, i_err, i_to_on, i_to_err, i_mon, i_oerr} = '0;
        i_used = 12'hfff; i_osup = 1'b1; i_usup = 1'b1; i_ce = 1'b1;
        i_reset = 1'b1;
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        // field patterns, with unused inputs and every diagnostic both ways
        for (int k = 0; k < 8; k++) begin
            @(posedge i_clk);
            i_on <= pat[k]; i_err <= pat[(k+3)%8]; i_used <= pat[(k+6)%8] | (k == 5 ? 12'hfff : 12'h0);
            i_to_on <= pat[(k+1)%8]; i_to_err <= pat[(k+3)%8]; i_mon <= pat[(k+2)%8][3:0];
            i_oerr <= pat[(k+3)%8][11:8]; i_lamp <= k[1:0]; i_osup <= k[0]; i_usup <= k[1];
            i_ooc <= k[2]; i_uoc <= ~k[0];
            settle();
            cmp_img(o_vendor_image, ev);
            cmp_img({80'h0, o_comb_image}, {84'h0, ev[83:80], ev[99], 3'h0, ev[11:0]});
            cmp_reg({16'h0, pw0}, {16'h0, ev[99], 3'h0, ev[11:0]});
            cmp_reg({24'h0, pb2}, {28'h0, ev[83:80]});
            cmp_reg({16'h0, pw[6]}, {24'h0, ev[103:96]});
        end
        // register view of the images and an unmapped place
        rd(siap_pkg::REG_COMB_LO, d);
        cmp_reg(d, {16'h0, ev[99], 3'h0, ev[11:0]});
        rd(8'h38, d);
        cmp_reg(d, {24'h0, ev[103:96]});
        rd(8'hfc, d);
        cmp_reg(d, 32'h0);
        // freeze holds the images while inputs move
        wr(siap_pkg::REG_CTRL, 32'h1);
        @(posedge i_clk);
        i_on <= ~i_on; i_used <= 12'hfff;
        repeat (2) @(posedge i_clk);
        #1 cmp_img(o_vendor_image, ev);
        cmp_reg({16'h0, pw[0]}, {16'h0, ev[15:0]});
        wr(siap_pkg::REG_CTRL, 32'h0);
        // clock enable low holds the vendor value word
        @(posedge i_clk);
        d = {20'h0, i_on & i_used};
        i_ce <= 1'b0; i_on <= 12'h000;
        settle();
        cmp_reg({20'h0, o_vendor_image[11:0]}, d);
        @(posedge i_clk);
        i_ce <= 1'b1; i_err <= '0; i_to_err <= '0; i_oerr <= '0; i_lamp <= 2'h3;
        i_osup <= 1'b1; i_usup <= 1'b1; i_ooc <= 1'b0; i_uoc <= 1'b0;
        settle();
        cmp_img(o_vendor_image, ev);
        // sticky status, mask and write-one-to-clear interrupt
        wr(siap_pkg::REG_STATUS, 32'h1f);
        rd(siap_pkg::REG_STATUS, d);
        cmp_reg(d, 32'h0);
        @(posedge i_clk);
        i_oerr <= 4'h4;
        settle();
        @(posedge i_clk);
        i_oerr <= 4'h0;
        rd(siap_pkg::REG_STATUS, d);
        cmp_reg(d, 32'h2);
        cmp_reg({31'h0, o_irq}, 32'h0);
        wr(siap_pkg::REG_MASK, 32'h2);
        #1 cmp_reg({31'h0, o_irq}, 32'h1);
        wr(siap_pkg::REG_STATUS, 32'h2);
        #1 cmp_reg({31'h0, o_irq}, 32'h0);
        rd(siap_pkg::REG_STATUS, d);
        cmp_reg(d, 32'h0);
        summarize();
    end
endmodule
